// [rsf_regs.sv]
// rsf_regs: collision position, signal strength/oscillator, two test
// registers and fifo status of the contactless reader front end.
// assumes host accesses arrive as one-cycle strobes from the serial or
// parallel port logic on clock_i, and receiver/fifo state on clock_i.
`timescale 1ns/1ps
module rsf_regs
  import rsf_pkg::*;
#(
  parameter int OSC_CYCLES = OSC_STABLE_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic enable_i,
  // host register port
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // collision / error position
  input wire logic collision_evt_i,
  input wire logic [9:0] collision_pos_i,
  output logic [1:0] collision_position_high_bit_o,
  // receiver state and levels
  input wire logic rx_active_i,
  input wire logic tx_active_i,
  input wire logic swap_channels_i,
  input wire logic [2:0] first_receive_input_i,
  input wire logic [2:0] second_receive_input_i,
  input wire logic [2:0] agc_level_i,
  output logic strength_valid_o,
  // test routing
  input wire logic keying_select_pin_i,
  input wire logic demod_data_i,
  input wire logic rx_subcarrier_i,
  input wire logic tx_modulation_i,
  input wire logic stop_condition_i,
  output logic decoder_data_o,
  output logic modulation_pin_o,
  output logic modulation_pin_oe_o,
  output logic direct_modulation_rx_reset_o,
  output logic second_stage_select_o,
  output logic second_stage_attenuate_o,
  output logic first_stage_attenuate_o,
  output logic follower_test_o,
  output logic rf_level_test_o,
  output logic [1:0] io_test_o,
  output logic decoder_test_o,
  output logic coder_fast_clock_o,
  output logic test_mode_o,
  // fifo state
  input wire logic [3:0] fifo_count_i,
  input wire logic fifo_overflow_evt_i
);

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [2:0] clamp_step(input logic [2:0] lvl);
    clamp_step = (lvl > STRENGTH_MAX_STEP) ? STRENGTH_MAX_STEP : lvl;
  endfunction

  localparam int OSC_W = $clog2(OSC_CYCLES + 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_CYCLES);

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [9:0] collision_reg;
  logic [7:0] rx_test_reg;
  logic [7:0] dec_test_reg;
  logic fifo_overflow_reg;
  logic strength_valid_reg;
  logic tx_active_d_reg;
  logic [OSC_W-1:0] osc_count_reg;
  logic osc_stable_reg;
  rsf_test_state_t test_state_reg;
  rsf_test_state_t test_state_next;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic decoder_data_reg;
  logic modulation_pin_reg;
  logic modulation_pin_oe_reg;
  logic [1:0] col_high_reg;

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  wire sel_collision = (reg_addr_i == ADDR_COLLISION_POSITION);
  wire sel_strength = (reg_addr_i == ADDR_SIGNAL_STRENGTH);
  wire sel_rx_test = (reg_addr_i == ADDR_RECEIVER_TEST);
  wire sel_dec_test = (reg_addr_i == ADDR_DECODER_TEST);
  wire sel_fifo = (reg_addr_i == ADDR_FIFO_STATUS);

  wire rd_collision = reg_rd_i && sel_collision;
  wire rd_fifo = reg_rd_i && sel_fifo;
  wire wr_rx_test = reg_wr_i && sel_rx_test;
  wire wr_dec_test = reg_wr_i && sel_dec_test;
  wire tx_start = tx_active_i && !tx_active_d_reg;

  // -----------------------------------------------------------------
  // collision position
  // -----------------------------------------------------------------
  // a new event in the read cycle survives the clear
  wire [9:0] collision_next = collision_evt_i ? collision_pos_i :
                              rd_collision ? {2'h0, COLLISION_RESET} :
                              collision_reg;

  // -----------------------------------------------------------------
  // signal strength channels
  // -----------------------------------------------------------------
  rsf_peak_if main_ch();
  rsf_peak_if aux_ch();

  // swap routes the first input to the auxiliary channel
  assign main_ch.level = clamp_step(swap_channels_i ? second_receive_input_i
                                                    : first_receive_input_i);
  assign aux_ch.level = clamp_step(swap_channels_i ? first_receive_input_i
                                                   : second_receive_input_i);
  assign main_ch.capture = rx_active_i;
  assign aux_ch.capture = rx_active_i;
  // enable low empties the peaks through the synchronous clear, never the async reset
  assign main_ch.clear = tx_active_i || !enable_i;
  assign aux_ch.clear = tx_active_i || !enable_i;

  rsf_peak_latch u_main_peak (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .port(main_ch.latch)
  );

  rsf_peak_latch u_aux_peak (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .port(aux_ch.latch)
  );

  wire [2:0] main_shown = rx_test_reg[RT_GAIN_OBSERVE] ? clamp_step(agc_level_i)
                                                        : main_ch.peak;
  wire [7:0] strength_word = {1'b0, osc_stable_reg, aux_ch.peak, main_shown};

  // valid from reception start until the next transmission starts
  wire strength_valid_next = tx_start ? 1'b0 :
                             (rx_active_i ? 1'b1 : strength_valid_reg);

  // -----------------------------------------------------------------
  // oscillator stable timer
  // -----------------------------------------------------------------
  // counts from reset release / enable; no real oscillator monitor here
  wire osc_done = (osc_count_reg == OSC_LAST);
  wire [OSC_W-1:0] osc_count_next = osc_done ? osc_count_reg
                                             : osc_count_reg + OSC_W'(1);

  // -----------------------------------------------------------------
  // test registers and test mode
  // -----------------------------------------------------------------
  wire test_bits_set = dec_test_reg[DT_DECODER_TEST] || dec_test_reg[DT_IO_TEST1]
                       || dec_test_reg[DT_IO_TEST0];
  wire [7:0] dec_test_clear_mask = ~((8'h1 << DT_DECODER_TEST) | (8'h1 << DT_IO_TEST1)
                                     | (8'h1 << DT_IO_TEST0));

  always_comb begin
    test_state_next = test_state_reg;
    case (test_state_reg)
      RSF_TEST_IDLE: begin
        if (test_bits_set) begin
          test_state_next = RSF_TEST_ACTIVE;
        end
      end
      RSF_TEST_ACTIVE: begin
        if (stop_condition_i) begin
          test_state_next = RSF_TEST_STOP;
        end
      end
      RSF_TEST_STOP: begin
        test_state_next = RSF_TEST_IDLE;
      end
      default: begin
        test_state_next = RSF_TEST_IDLE;
      end
    endcase
  end

  wire stop_clears = (test_state_reg == RSF_TEST_ACTIVE) && stop_condition_i;
  // a write in the stop cycle wins and lands whole; the clear of the test bits is dropped for that cycle
  wire [7:0] dec_test_next = wr_dec_test ? (reg_wdata_i & DT_WRITE_MASK) :
                             stop_clears ? (dec_test_reg & dec_test_clear_mask) :
                             dec_test_reg;

  // -----------------------------------------------------------------
  // fifo status
  // -----------------------------------------------------------------
  wire fifo_high = rx_active_i && (fifo_count_i >= FIFO_HIGH_LEVEL);
  wire fifo_low = tx_active_i && (fifo_count_i <= FIFO_LOW_LEVEL);
  wire [3:0] fifo_count_m1 = (fifo_count_i == 4'h0) ? 4'h0
                                                      : fifo_count_i - 4'h1;
  // overflow is sticky until read; an overflow in the read cycle wins
  wire fifo_overflow_next = fifo_overflow_evt_i ? 1'b1 :
                            rd_fifo ? 1'b0 : fifo_overflow_reg;
  wire [7:0] fifo_word = {1'b0, fifo_high, fifo_low, fifo_overflow_reg,
                          fifo_count_m1};

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  wire [7:0] read_word = sel_collision ? collision_reg[7:0] :
                         sel_strength ? strength_word :
                         sel_rx_test ? rx_test_reg :
                         sel_dec_test ? dec_test_reg :
                         sel_fifo ? fifo_word : 8'h00;

  // -----------------------------------------------------------------
  // pin routing
  // -----------------------------------------------------------------
  logic keying_sync;

  rsf_sync3 u_keying_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i(keying_select_pin_i),
    .sync_o(keying_sync)
  );

  wire decoder_data_next = rx_test_reg[RT_KEYING_DECODER_IN] ? keying_sync
                                                             : demod_data_i;
  wire mod_sub_out = rx_test_reg[RT_MOD_SUBCARRIER_OUT];
  wire modulation_pin_next = mod_sub_out ? rx_subcarrier_i : tx_modulation_i;

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  // enable low acts as a synchronous clear of the register state in this block; the output stage flops are not cleared
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      collision_reg <= 10'h000;
      rx_test_reg <= TEST_RESET;
      dec_test_reg <= TEST_RESET;
      fifo_overflow_reg <= 1'b0;
      strength_valid_reg <= 1'b0;
      tx_active_d_reg <= 1'b0;
      osc_count_reg <= '0;
      osc_stable_reg <= 1'b0;
      test_state_reg <= RSF_TEST_IDLE;
    end else if (ce_i) begin
      if (!enable_i) begin
        collision_reg <= 10'h000;
        rx_test_reg <= TEST_RESET;
        dec_test_reg <= TEST_RESET;
        fifo_overflow_reg <= 1'b0;
        strength_valid_reg <= 1'b0;
        tx_active_d_reg <= 1'b0;
        osc_count_reg <= '0;
        osc_stable_reg <= 1'b0;
        test_state_reg <= RSF_TEST_IDLE;
      end else begin
        collision_reg <= collision_next;
        if (wr_rx_test) begin
          rx_test_reg <= reg_wdata_i;
        end
        dec_test_reg <= dec_test_next;
        fifo_overflow_reg <= fifo_overflow_next;
        strength_valid_reg <= strength_valid_next;
        tx_active_d_reg <= tx_active_i;
        osc_count_reg <= osc_count_next;
        osc_stable_reg <= osc_done;
        test_state_reg <= test_state_next;
      end
    end
  end

  // output stage: every output straight from a flip-flop
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      decoder_data_reg <= 1'b0;
      modulation_pin_reg <= 1'b0;
      modulation_pin_oe_reg <= 1'b0;
      col_high_reg <= 2'h0;
    end else if (ce_i) begin
      rvalid_reg <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_reg <= read_word;
      end
      decoder_data_reg <= decoder_data_next;
      modulation_pin_reg <= modulation_pin_next;
      modulation_pin_oe_reg <= enable_i;
      col_high_reg <= collision_next[9:8];
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign collision_position_high_bit_o = col_high_reg;
  assign strength_valid_o = strength_valid_reg;
  assign decoder_data_o = decoder_data_reg;
  assign modulation_pin_o = modulation_pin_reg;
  assign modulation_pin_oe_o = modulation_pin_oe_reg;
  assign direct_modulation_rx_reset_o = rx_test_reg[RT_DIRECT_MOD];
  assign second_stage_select_o = rx_test_reg[RT_STAGE_SELECT];
  assign second_stage_attenuate_o = rx_test_reg[RT_SECOND_ATTEN];
  assign first_stage_attenuate_o = rx_test_reg[RT_FIRST_ATTEN];
  assign follower_test_o = rx_test_reg[RT_FOLLOWER_TEST];
  assign rf_level_test_o = dec_test_reg[DT_RF_LEVEL_TEST];
  assign io_test_o = {dec_test_reg[DT_IO_TEST1], dec_test_reg[DT_IO_TEST0]};
  assign decoder_test_o = dec_test_reg[DT_DECODER_TEST];
  assign coder_fast_clock_o = dec_test_reg[DT_CODER_FAST_CLOCK];
  // one-hot active bit, so the output is a plain flop
  assign test_mode_o = test_state_reg[1];

endmodule

// [rsf_pkg.sv]
// rsf_pkg: offsets, field positions, reset values and timing for the
// reader status/test/fifo register group.
// assumes a 100 MHz system clock and a host access port on that clock.
package rsf_pkg;

  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [4:0] ADDR_COLLISION_POSITION = 5'h0e;
  localparam logic [4:0] ADDR_SIGNAL_STRENGTH = 5'h0f;
  localparam logic [4:0] ADDR_RECEIVER_TEST = 5'h1a;
  localparam logic [4:0] ADDR_DECODER_TEST = 5'h1b;
  localparam logic [4:0] ADDR_FIFO_STATUS = 5'h1c;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] COLLISION_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET = 8'h00;

  // -----------------------------------------------------------------
  // receiver_test_control fields
  // -----------------------------------------------------------------
  localparam int RT_KEYING_DECODER_IN = 7;
  localparam int RT_MOD_SUBCARRIER_OUT = 6;
  localparam int RT_DIRECT_MOD = 5;
  localparam int RT_STAGE_SELECT = 4;
  localparam int RT_SECOND_ATTEN = 3;
  localparam int RT_FIRST_ATTEN = 2;
  localparam int RT_FOLLOWER_TEST = 1;
  localparam int RT_GAIN_OBSERVE = 0;

  // -----------------------------------------------------------------
  // decoder_test_control fields
  // -----------------------------------------------------------------
  localparam int DT_RF_LEVEL_TEST = 7;
  localparam int DT_IO_TEST1 = 3;
  localparam int DT_IO_TEST0 = 2;
  localparam int DT_DECODER_TEST = 1;
  localparam int DT_CODER_FAST_CLOCK = 0;
  localparam logic [7:0] DT_WRITE_MASK = 8'h8f;

  // -----------------------------------------------------------------
  // signal_strength_osc_status and fifo_status fields
  // -----------------------------------------------------------------
  localparam int SS_OSC_STABLE = 6;
  localparam int FS_HIGH = 6;
  localparam int FS_LOW = 5;
  localparam int FS_OVERFLOW = 4;

  // -----------------------------------------------------------------
  // levels and timing
  // -----------------------------------------------------------------
  localparam logic [2:0] STRENGTH_MAX_STEP = 3'h7;
  localparam logic [3:0] FIFO_HIGH_LEVEL = 4'h9;
  localparam logic [3:0] FIFO_LOW_LEVEL = 4'h3;
  localparam int CLOCK_MHZ = 100;
  localparam int OSC_STABLE_US = 200;
  localparam int OSC_STABLE_CYCLES = OSC_STABLE_US * CLOCK_MHZ;

  typedef enum logic [2:0] {
    RSF_TEST_IDLE = 3'b001,
    RSF_TEST_ACTIVE = 3'b010,
    RSF_TEST_STOP = 3'b100
  } rsf_test_state_t;

endpackage

// [rsf_peak_if.sv]
// rsf_peak_if: one receive channel between the register group and its
// peak-level latch.
// assumes both ends share the system clock.
`timescale 1ns/1ps
interface rsf_peak_if;
  logic [2:0] level;
  logic capture;
  logic clear;
  logic [2:0] peak;

  modport ctrl (output level, output capture, output clear, input peak);
  modport latch (input level, input capture, input clear, output peak);
endinterface

// [rsf_sync3.sv]
// rsf_sync3: three-stage pin synchroniser; output changes only when the
// second and third stages agree.
// assumes an asynchronous input and a free-running clock.
`timescale 1ns/1ps
module rsf_sync3 (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic async_i,
  output logic sync_o
);
  logic [2:0] stage_reg;
  logic out_reg;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_reg <= 3'h0;
      out_reg <= 1'b0;
    end else if (ce_i) begin
      stage_reg <= {stage_reg[1:0], async_i};
      if (stage_reg[1] == stage_reg[2]) begin
        out_reg <= stage_reg[2];
      end
    end
  end

  assign sync_o = out_reg;
endmodule

// [rsf_peak_latch.sv]
// rsf_peak_latch: holds the highest envelope step seen while capturing.
// assumes level already clamped to the eight valid steps, 0 to 7.
`timescale 1ns/1ps
module rsf_peak_latch (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  rsf_peak_if.latch port
);
  logic [2:0] peak_reg;
  logic [2:0] peak_next;

  // clear wins so a new transmit always starts from zero
  assign peak_next = port.clear ? 3'h0 :
                     (port.capture && (port.level > peak_reg)) ? port.level : peak_reg;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      peak_reg <= 3'h0;
    end else if (ce_i) begin
      peak_reg <= peak_next;
    end
  end

  assign port.peak = peak_reg;
endmodule

// [rsf_regs_asserts.sv]
// rsf_regs_asserts: port-level checks of the register group.
// assumes it is bound to every rsf_regs instance.
`timescale 1ns/1ps
module rsf_regs_asserts
  import rsf_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic enable_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic collision_evt_i,
  input wire logic rx_active_i,
  input wire logic tx_active_i,
  input wire logic stop_condition_i,
  input wire logic test_mode_o,
  input wire logic [1:0] io_test_o,
  input wire logic decoder_test_o,
  input wire logic rf_level_test_o,
  input wire logic coder_fast_clock_o,
  input wire logic second_stage_select_o,
  input wire logic second_stage_attenuate_o,
  input wire logic first_stage_attenuate_o,
  input wire logic [3:0] fifo_count_i
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire rd = reg_rd_i && ce_i;
  wire rd_f = rd && reg_addr_i == ADDR_FIFO_STATUS;
  wire rd_c = rd && reg_addr_i == ADDR_COLLISION_POSITION && !collision_evt_i;
  wire wr_t = reg_wr_i && ce_i && enable_i && reg_addr_i == ADDR_RECEIVER_TEST;
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  a_read_answer: assert property (rd |=> reg_rvalid_o) else $error("no read answer");
  a_fifo_rsvd_zero: assert property (rd_f |=> !reg_rdata_o[7]) else $error("fifo b7 set");
  a_fifo_count_field: assert property (rd_f && fifo_count_i != 4'h0 |=>
    reg_rdata_o[3:0] == $past(fifo_count_i) - 4'h1) else $error("fifo count");
  a_fifo_high_flag: assert property (rd_f |=>
    reg_rdata_o[6] == $past(rx_active_i && fifo_count_i >= FIFO_HIGH_LEVEL)) else $error("high");
  a_fifo_low_flag: assert property (rd_f |=>
    reg_rdata_o[5] == $past(tx_active_i && fifo_count_i <= FIFO_LOW_LEVEL)) else $error("low");
  a_collision_read_clear: assert property (rd_c ##1 !collision_evt_i ##1 rd_c |=>
    reg_rdata_o == 8'h00) else $error("collision not cleared");
  a_stop_ends_test: assert property (stop_condition_i && test_mode_o && ce_i && !reg_wr_i
    |=> !decoder_test_o && io_test_o == 2'h0) else $error("test bits kept");
  a_enable_clears_test: assert property (!enable_i && ce_i
    |=> !rf_level_test_o && !coder_fast_clock_o && !second_stage_select_o) else $error("en");
  a_stage_bits_write: assert property (wr_t |=>
    second_stage_select_o == $past(reg_wdata_i[4]) && second_stage_attenuate_o ==
    $past(reg_wdata_i[3]) && first_stage_attenuate_o == $past(reg_wdata_i[2]))
    else $error("stage bits");
endmodule
bind rsf_regs rsf_regs_asserts chk (.*);

// [rsf_host_model.sv]
// rsf_host_model: host microcontroller issuing single-byte register accesses.
// assumes the one-cycle read answer of the register port.
`timescale 1ns/1ps
module rsf_host_model (
  input wire logic clock_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic [4:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 5'h00;
    reg_wr_o = 1'h0;
    reg_rd_o = 1'h0;
    reg_wdata_o = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'h1;
    @(negedge clock_i);
    reg_wr_o = 1'h0;
    // released address and data show the inverse, not a stale copy
    reg_wdata_o = ~d;
    reg_addr_o = ~a;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
    @(negedge clock_i);
    reg_addr_o = a;
    reg_rd_o = 1'h1;
    @(negedge clock_i);
    d = reg_rdata_i;
    v = reg_rvalid_i;
    reg_rd_o = 1'h0;
    reg_addr_o = ~a;
  endtask
endmodule

// [reader_status_test_fifo_regs_test.sv]
// reader_status_test_fifo_regs_test: self-checking bench of rsf_regs.
// assumes rsf_host_model as register master and the bound checker.
`timescale 1ns/1ps
module reader_status_test_fifo_regs_test
  import rsf_pkg::*;
;
  logic clock_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1, enable_i = 1'h1, collision_evt_i = 1'h0;
  logic rx_active_i = 1'h0, tx_active_i = 1'h0, swap_channels_i = 1'h0, stop_condition_i = 1'h0;
  logic keying_select_pin_i = 1'h0, demod_data_i = 1'h0, rx_subcarrier_i = 1'h0;
  logic tx_modulation_i = 1'h0, fifo_overflow_evt_i = 1'h0;
  logic [2:0] first_receive_input_i = 3'h0, second_receive_input_i = 3'h0, agc_level_i = 3'h0;
  logic [3:0] fifo_count_i = 4'h0;
  logic [9:0] collision_pos_i = 10'h000;
  wire [4:0] reg_addr_i;
  wire [7:0] reg_wdata_i, reg_rdata_o;
  wire [1:0] collision_position_high_bit_o, io_test_o;
  wire reg_wr_i, reg_rd_i, reg_rvalid_o, strength_valid_o, decoder_data_o, modulation_pin_o;
  wire modulation_pin_oe_o, direct_modulation_rx_reset_o, second_stage_select_o, test_mode_o;
  wire second_stage_attenuate_o, first_stage_attenuate_o, follower_test_o, rf_level_test_o;
  wire decoder_test_o, coder_fast_clock_o;
  int n_mismatch = 0, n_checks = 0, cyc = 0, p1, p2;
  logic [7:0] d;
  logic k, s;
  rsf_regs #(.OSC_CYCLES(50)) uut (.*);
  rsf_host_model host (.clock_i(clock_i), .reg_rdata_i(reg_rdata_o),
    .reg_rvalid_i(reg_rvalid_o), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));
  always #5 clock_i = ~clock_i;
  // -----------------------------------------------------------------
  // compare and bus helpers
  // -----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp, input string m);
    chk({7'h00, got}, {7'h00, exp}, m);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e, input logic [7:0] mk);
    logic [7:0] r;
    logic v;
    host.rd(a, r, v);
    chk_pin(v, 1'h1, "rvalid");
    chk(r & mk, e & mk, "read data");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(32'h06a7));
    repeat (5) @(posedge clock_i);
    @(negedge clock_i) rst_n_i = 1'h1;
    rd_chk(ADDR_SIGNAL_STRENGTH, 8'h00, 8'h40);
    rd_chk(ADDR_RECEIVER_TEST, TEST_RESET, 8'hff);
    rd_chk(ADDR_DECODER_TEST, TEST_RESET, 8'hff);
    rd_chk(ADDR_COLLISION_POSITION, COLLISION_RESET, 8'hff);
    rd_chk(5'h03, 8'h00, 8'hff);
    repeat (3) begin
      d = 8'($urandom);
      host.wr(ADDR_RECEIVER_TEST, d);
      rd_chk(ADDR_RECEIVER_TEST, d, 8'hff);
      chk_pin(second_stage_attenuate_o, d[3], "atten2");
      chk_pin(first_stage_attenuate_o, d[2], "atten1");
      chk_pin(direct_modulation_rx_reset_o, d[5], "direct mod");
      chk_pin(follower_test_o, d[1], "follower");
    end
    for (int sel = 1; sel >= 0; sel--) begin
      host.wr(ADDR_RECEIVER_TEST, sel ? 8'hc0 : 8'h00);
      repeat (4) begin
        @(negedge clock_i);
        {k, s, demod_data_i, tx_modulation_i} = 4'($urandom);
        keying_select_pin_i = k;
        rx_subcarrier_i = s;
        repeat (6) @(negedge clock_i);
        chk_pin(decoder_data_o, sel ? k : demod_data_i, "decoder in");
        chk_pin(modulation_pin_o, sel ? s : tx_modulation_i, "mod pin");
        chk_pin(modulation_pin_oe_o, 1'h1, "mod oe");
      end
    end
    p1 = 0;
    p2 = 0;
    rx_active_i = 1'h1;
    repeat (6) begin
      @(negedge clock_i);
      {first_receive_input_i, second_receive_input_i} = 6'($urandom);
      p1 = first_receive_input_i > p1 ? first_receive_input_i : p1;
      p2 = second_receive_input_i > p2 ? second_receive_input_i : p2;
    end
    @(negedge clock_i) rx_active_i = 1'h0;
    repeat (3) @(negedge clock_i);
    rd_chk(ADDR_SIGNAL_STRENGTH, {2'h1, 3'(p2), 3'(p1)}, 8'hff);
    chk_pin(strength_valid_o, 1'h1, "valid in rx");
    agc_level_i = 3'($urandom);
    host.wr(ADDR_RECEIVER_TEST, 8'h01);
    rd_chk(ADDR_SIGNAL_STRENGTH, {5'h00, agc_level_i}, 8'h07);
    host.wr(ADDR_RECEIVER_TEST, 8'h00);
    tx_active_i = 1'h1;
    repeat (3) @(negedge clock_i);
    chk_pin(strength_valid_o, 1'h0, "valid in tx");
    tx_active_i = 1'h0;
    rd_chk(ADDR_SIGNAL_STRENGTH, 8'h40, 8'hff);
    // swap acts on what is captured, so it is set before the reception
    swap_channels_i = 1'h1;
    rx_active_i = 1'h1;
    {first_receive_input_i, second_receive_input_i} = 6'($urandom);
    p1 = first_receive_input_i;
    p2 = second_receive_input_i;
    repeat (2) @(negedge clock_i);
    rx_active_i = 1'h0;
    rd_chk(ADDR_SIGNAL_STRENGTH, {2'h1, 3'(p1), 3'(p2)}, 8'hff);
    swap_channels_i = 1'h0;
    repeat (3) begin
      @(negedge clock_i);
      collision_pos_i = 10'($urandom);
      collision_evt_i = 1'h1;
      @(negedge clock_i);
      collision_evt_i = 1'h0;
      d = collision_pos_i[7:0];
      k = collision_pos_i[9];
      s = collision_pos_i[8];
      collision_pos_i = ~collision_pos_i;
      @(negedge clock_i);
      chk({6'h00, collision_position_high_bit_o}, {6'h00, k, s}, "col high");
      rd_chk(ADDR_COLLISION_POSITION, d, 8'hff);
      rd_chk(ADDR_COLLISION_POSITION, 8'h00, 8'hff);
    end
    // an event while the clock enable is low must not land
    @(negedge clock_i) ce_i = 1'h0;
    collision_evt_i = 1'h1;
    @(negedge clock_i) ce_i = 1'h1;
    collision_evt_i = 1'h0;
    rd_chk(ADDR_COLLISION_POSITION, 8'h00, 8'hff);
    for (int c = 0; c <= 12; c++) begin
      for (int m = 0; m < 3; m++) begin
        @(negedge clock_i);
        fifo_count_i = 4'(c);
        rx_active_i = m == 1;
        tx_active_i = m == 2;
        d = {1'h0, m == 1 && c >= 9, m == 2 && c <= 3, 1'h0, 4'(c == 0 ? 0 : c - 1)};
        rd_chk(ADDR_FIFO_STATUS, d, 8'hff);
      end
    end
    rx_active_i = 1'h0;
    tx_active_i = 1'h0;
    @(negedge clock_i) fifo_overflow_evt_i = 1'h1;
    @(negedge clock_i) fifo_overflow_evt_i = 1'h0;
    rd_chk(ADDR_FIFO_STATUS, 8'h10, 8'h10);
    rd_chk(ADDR_FIFO_STATUS, 8'h00, 8'h10);
    d = 8'($urandom) | 8'h02;
    host.wr(ADDR_DECODER_TEST, d);
    rd_chk(ADDR_DECODER_TEST, d & DT_WRITE_MASK, 8'hff);
    chk_pin(coder_fast_clock_o, d[0], "fast clock");
    chk_pin(test_mode_o, 1'h1, "test mode on");
    @(negedge clock_i) stop_condition_i = 1'h1;
    @(negedge clock_i) stop_condition_i = 1'h0;
    @(negedge clock_i);
    chk_pin(test_mode_o, 1'h0, "test mode off");
    rd_chk(ADDR_DECODER_TEST, d & 8'h81, 8'hff);
    host.wr(ADDR_RECEIVER_TEST, 8'hff);
    @(negedge clock_i) enable_i = 1'h0;
    @(negedge clock_i) enable_i = 1'h1;
    rd_chk(ADDR_RECEIVER_TEST, 8'h00, 8'hff);
    rd_chk(ADDR_DECODER_TEST, 8'h00, 8'hff);
    rd_chk(ADDR_SIGNAL_STRENGTH, 8'h00, 8'h40);
    report_and_stop();
  end
endmodule
